// *** def_pickup.sv ***
`timescale 1ns/1ps
module directional_earth_fault_pickup
  import def_pickup_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    sys_rst_in,
  // settings from the active group
  input  wire logic [1:0]              grounding_type_in,
  input  wire logic [MAG_W-1:0]        cur_thr_unearthed_in,
  input  wire logic [MAG_W-1:0]        cur_thr_compensated_in,
  input  wire logic [MAG_W-1:0]        volt_thr_unearthed_in,
  input  wire logic [MAG_W-1:0]        volt_thr_compensated_in,
  input  wire logic                    mcd_enable_in,
  input  wire logic signed [ANG_W-1:0] border_angle_in,
  input  wire logic signed [ANG_W-1:0] blinder_angle_in,
  input  wire logic signed [ANG_W-1:0] sector_size_in,
  input  wire logic signed [ANG_W-1:0] sector_centre_in,
  input  wire logic                    invert_reference_in,
  // measurements
  input  wire logic [MAG_W-1:0]        measured_magnitude_in,
  input  wire logic [MAG_W-1:0]        voltage_magnitude_in,
  input  wire logic signed [ANG_W-1:0] angle_in,
  input  wire logic                    mcd_fault_in,
  // results
  output logic                         pickup_out,
  output logic                         pickup_unearthed_out,
  output logic                         pickup_compensated_out,
  output logic                         angle_valid_out
);
  // ********************************************
  // helpers
  // ********************************************
  function automatic logic signed [ANG_W-1:0] wrap(input logic signed [ANG_W+1:0] a);
    logic signed [ANG_W+1:0] r;
    r = a;
    if (r > ANG_180) r = r - ANG_360;
    if (r <= -ANG_180) r = r + ANG_360;
    if (r > ANG_180) r = r - ANG_360;
    if (r <= -ANG_180) r = r + ANG_360;
    return r[ANG_W-1:0];
  endfunction

  // hysteresis compare: set above thr, hold until below 97 % of thr
  function automatic logic over(input logic [MAG_W-1:0] m, input logic [MAG_W-1:0] t,
                                input logic held);
    logic [MAG_W+7:0] ms;
    logic [MAG_W+7:0] ts;
    ms = {8'h00, m} * (MAG_W+8)'(RESET_DEN);
    ts = {8'h00, t} * (MAG_W+8)'(RESET_NUM);
    if (held) return ms >= ts;
    return m > t;
  endfunction

  // ********************************************
  // input synchronisers
  // ********************************************
  logic [MAG_W-1:0] im_s1, im_s2, um_s1, um_s2;
  logic signed [ANG_W-1:0] an_s1, an_s2;
  logic mcd_s1, mcd_s2;
  logic [MAG_W-1:0] next_im_s1, next_um_s1;
  logic signed [ANG_W-1:0] next_an_s1;
  logic next_mcd_s1;

  always_comb begin
    next_im_s1  = measured_magnitude_in;
    next_um_s1  = voltage_magnitude_in;
    next_an_s1  = angle_in;
    next_mcd_s1 = mcd_fault_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      im_s1  <= '0;
      im_s2  <= '0;
      um_s1  <= '0;
      um_s2  <= '0;
      an_s1  <= '0;
      an_s2  <= '0;
      mcd_s1 <= 1'b0;
      mcd_s2 <= 1'b0;
    end else begin
      im_s1  <= next_im_s1;
      im_s2  <= im_s1;
      um_s1  <= next_um_s1;
      um_s2  <= um_s1;
      an_s1  <= next_an_s1;
      an_s2  <= an_s1;
      mcd_s1 <= next_mcd_s1;
      mcd_s2 <= mcd_s1;
    end
  end

  // ********************************************
  // angle regions
  // ********************************************
  logic signed [ANG_W-1:0] phi, rel;
  logic valid, sq_pass, in_unearthed, in_comp, in_sector;
  grounding_t gtype;

  always_comb begin
    gtype   = grounding_t'(grounding_type_in);
    sq_pass = (im_s2 > CUR_SQUELCH) && (um_s2 > VOLT_SQUELCH);
    // inverted reference shifts by half a turn
    phi = invert_reference_in ? wrap({{2{an_s2[ANG_W-1]}}, an_s2} + ANG_180)
                              : an_s2;
    // unearthed: current lags voltage by 90, forward half plane
    in_unearthed = (phi < 0) && (phi > -ANG_180);
    // compensated: resistive component opposes voltage
    in_comp = (phi > ANG_90) || (phi < -ANG_90);
    // blinder narrows the lagging side of the resistive region
    if (blinder_angle_in != 0)
      in_comp = in_comp && !((phi < 0) && (phi >= -ANG_180 - blinder_angle_in));
    rel = wrap({{2{phi[ANG_W-1]}}, phi} - {{2{sector_centre_in[ANG_W-1]}}, sector_centre_in});
    in_sector = (rel <= sector_size_in) && (rel >= -sector_size_in);
    if (gtype == GND_BROAD) begin
      // border divides overlap between the two regions
      in_comp      = in_comp && !(phi < 0 && phi > -ANG_180 + border_angle_in);
      in_unearthed = in_unearthed && !in_comp;
    end
    valid = sq_pass;
  end

  // ********************************************
  // pick-up state
  // ********************************************
  logic pu_u, pu_c, next_pu_u, next_pu_c;
  logic cur_u, cur_c, volt_u, volt_c;

  always_comb begin
    cur_u  = over(im_s2, cur_thr_unearthed_in, pu_u);
    cur_c  = over(im_s2, cur_thr_compensated_in, pu_c);
    volt_u = over(um_s2, volt_thr_unearthed_in, pu_u);
    volt_c = over(um_s2, volt_thr_compensated_in, pu_c);
    next_pu_u = 1'b0;
    next_pu_c = 1'b0;
    unique case (gtype)
      GND_UNEARTHED:   next_pu_u = cur_u && volt_u && valid && in_unearthed;
      GND_COMPENSATED: next_pu_c = cur_c && volt_c && valid && in_comp;
      GND_GROUNDED:    next_pu_u = cur_u && volt_u && valid && in_sector;
      GND_BROAD: begin
        next_pu_u = cur_u && volt_u && valid && in_unearthed;
        next_pu_c = cur_c && volt_c && valid && in_comp
                    && (!mcd_enable_in || mcd_s2);
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pu_u <= 1'b0;
      pu_c <= 1'b0;
      angle_valid_out <= 1'b0;
    end else begin
      pu_u <= next_pu_u;
      pu_c <= next_pu_c;
      angle_valid_out <= valid;
    end
  end

  assign pickup_unearthed_out   = pu_u;
  assign pickup_compensated_out = pu_c;
  assign pickup_out             = pu_u | pu_c;
endmodule

// *** def_pickup_checker.sv ***
`timescale 1ns/1ps
module def_pickup_checker
  import def_pickup_pkg::*;
(
  // clock and reset
  input wire logic                    ref_clk_in,
  input wire logic                    sys_rst_in,
  // settings and measurements
  input wire logic [1:0]              grounding_type_in,
  input wire logic [MAG_W-1:0]        cur_thr_unearthed_in,
  input wire logic [MAG_W-1:0]        volt_thr_unearthed_in,
  input wire logic                    invert_reference_in,
  input wire logic [MAG_W-1:0]        measured_magnitude_in,
  input wire logic [MAG_W-1:0]        voltage_magnitude_in,
  input wire logic signed [ANG_W-1:0] angle_in,
  // results
  input wire logic                    pickup_out,
  input wire logic                    pickup_unearthed_out,
  input wire logic                    pickup_compensated_out,
  input wire logic                    angle_valid_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ****************************************
  // output relations
  // ****************************************
  pickup_or_a: assert property (pickup_out == (pickup_unearthed_out | pickup_compensated_out))
    else $error("pickup is not the or of the stage outputs");
  cur_squelch_a: assert property (measured_magnitude_in <= CUR_SQUELCH |-> ##3 !angle_valid_out)
    else $error("angle valid with current under squelch");
  volt_squelch_a: assert property (voltage_magnitude_in <= VOLT_SQUELCH |-> ##3 !angle_valid_out)
    else $error("angle valid with voltage under squelch");
  need_angle_a: assert property (pickup_out |-> angle_valid_out)
    else $error("pickup without valid angle");
  cur_release_a: assert property ((grounding_type_in == GND_UNEARTHED) &&
    (int'($past(measured_magnitude_in, 2)) * RESET_DEN < int'(cur_thr_unearthed_in) * RESET_NUM)
    |-> ##1 !pickup_unearthed_out)
    else $error("pickup held below current hysteresis");
  volt_release_a: assert property ((grounding_type_in == GND_UNEARTHED) &&
    (int'($past(voltage_magnitude_in, 2)) * RESET_DEN < int'(volt_thr_unearthed_in) * RESET_NUM)
    |-> ##1 !pickup_unearthed_out)
    else $error("pickup held below voltage hysteresis");
  reverse_a: assert property ((grounding_type_in == GND_UNEARTHED) && !invert_reference_in &&
    ($past(angle_in, 2) >= BORDER_DEF) && ($past(angle_in, 2) <= ANG_90 + BORDER_DEF)
    |-> ##1 !pickup_unearthed_out)
    else $error("pickup on reverse current");
  rise_late_a: assert property ($rose(pickup_out) |-> $past(measured_magnitude_in, 3) > CUR_SQUELCH)
    else $error("pickup rose without current");
endmodule
bind directional_earth_fault_pickup def_pickup_checker chk (.*);

// *** def_pickup_pkg.sv ***
// Overview of operation
// - pick-up when current exceeds current threshold
// - release below 97 percent of threshold
// - also need voltage and valid angle
// - four grounding types, unearthed default
// - current threshold in milli-nominal steps, 1.20
// - voltage threshold hundredth percent, default 20
// - multi-criteria option only in broad range
// - broad range border angle, default 45
// - compensated blinder, zero disables, default -90
// - grounded sector half width, default 88
// - grounded sector centre rotation, default zero
// - unearthed forward: current lags voltage 90
// - compensated forward: resistive current opposes voltage
// - settings may change while running
// - angle valid only above one percent squelch
// - reference polarity option inverts voltage
package def_pickup_pkg;
  // ********************************************
  // grounding types
  // ********************************************
  typedef enum logic [1:0] {
    GND_UNEARTHED   = 2'b00,
    GND_COMPENSATED = 2'b01,
    GND_GROUNDED    = 2'b10,
    GND_BROAD       = 2'b11
  } grounding_t;

  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_UNEARTHED  = 2'b01,
    ST_COMPENSATE = 2'b10,
    ST_GROUNDED   = 2'b11
  } pick_state_t;

  // ********************************************
  // scaling: current in 0.001 In, voltage in 0.01 %Un, angle in 0.1 deg
  // ********************************************
  localparam int        MAG_W          = 18;
  localparam int        ANG_W          = 13;
  localparam logic [17:0] CUR_DEFAULT  = 18'h004B0;  // 1200 = 1.20 In
  localparam logic [17:0] VOLT_DEFAULT = 18'h007D0;  // 2000 = 20 %Un
  localparam logic [17:0] CUR_SQUELCH  = 18'h0000A;  // 10 = 0.01 In
  localparam logic [17:0] VOLT_SQUELCH = 18'h00064;  // 100 = 1 %Un
  localparam int        RESET_NUM      = 97;
  localparam int        RESET_DEN      = 100;
  localparam logic signed [12:0] ANG_90     = 13'sh0384;
  localparam logic signed [12:0] ANG_180    = 13'sh0708;
  localparam logic signed [12:0] ANG_360    = 13'sh0E10;
  localparam logic signed [12:0] BORDER_DEF = 13'sh01C2;  // 45.0
  localparam logic signed [12:0] BLIND_DEF  = -13'sh0384; // -90.0
  localparam logic signed [12:0] SIZE_DEF   = 13'sh0370;  // 88.0
  localparam logic signed [12:0] CENTRE_DEF = 13'sh0000;
endpackage

// *** test_directional_earth_fault_pickup.sv ***
`timescale 1ns/1ps
module test_directional_earth_fault_pickup;
  import def_pickup_pkg::*;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, mcd_enable_in = 1'b0, invert_reference_in = 1'b0;
  logic mcd_fault_in = 1'b0;
  logic [1:0] grounding_type_in = GND_UNEARTHED;
  logic [MAG_W-1:0] cur_thr_unearthed_in = CUR_DEFAULT, measured_magnitude_in = 18'h00000;
  logic [MAG_W-1:0] voltage_magnitude_in = 18'h00000;
  logic signed [ANG_W-1:0] blinder_angle_in = BLIND_DEF, sector_centre_in = CENTRE_DEF;
  logic signed [ANG_W-1:0] angle_in = 13'sh0000;
  logic pickup_out, pickup_unearthed_out, pickup_compensated_out, angle_valid_out;
  int miscompares = 0, check_count = 0;
  directional_earth_fault_pickup uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .grounding_type_in(grounding_type_in), .cur_thr_unearthed_in(cur_thr_unearthed_in),
    .cur_thr_compensated_in(CUR_DEFAULT), .volt_thr_unearthed_in(VOLT_DEFAULT),
    .volt_thr_compensated_in(VOLT_DEFAULT), .mcd_enable_in(mcd_enable_in),
    .border_angle_in(BORDER_DEF), .blinder_angle_in(blinder_angle_in),
    .sector_size_in(SIZE_DEF), .sector_centre_in(sector_centre_in),
    .invert_reference_in(invert_reference_in), .measured_magnitude_in(measured_magnitude_in),
    .voltage_magnitude_in(voltage_magnitude_in), .angle_in(angle_in), .mcd_fault_in(mcd_fault_in),
    .pickup_out(pickup_out), .pickup_unearthed_out(pickup_unearthed_out),
    .pickup_compensated_out(pickup_compensated_out), .angle_valid_out(angle_valid_out));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic meas(input logic [MAG_W-1:0] c, input logic [MAG_W-1:0] v,
                      input logic signed [ANG_W-1:0] a);
    @(posedge ref_clk_in);
    measured_magnitude_in <= c;
    voltage_magnitude_in <= v;
    angle_in <= a;
    repeat (5) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk("reset pickup", 1'b0, pickup_out);
    meas(18'h00514, 18'h009C4, -13'sh0384);
    chk("forward pickup", 1'b1, pickup_out);
    chk("unearthed stage", 1'b1, pickup_unearthed_out);
    chk("angle valid", 1'b1, angle_valid_out);
    meas(18'h0049C, 18'h009C4, -13'sh0384);
    chk("hysteresis hold", 1'b1, pickup_out);
    meas(18'h0044C, 18'h009C4, -13'sh0384);
    chk("hysteresis drop", 1'b0, pickup_out);
    meas(18'h00514, 18'h005DC, -13'sh0384);
    chk("low voltage", 1'b0, pickup_out);
    meas(18'h00514, 18'h009C4, 13'sh0384);
    chk("reverse current", 1'b0, pickup_out);
    invert_reference_in <= 1'b1;
    meas(18'h00514, 18'h009C4, 13'sh0384);
    chk("inverted reference", 1'b1, pickup_out);
    invert_reference_in <= 1'b0;
    meas(18'h00005, 18'h009C4, -13'sh0384);
    chk("current squelch", 1'b0, angle_valid_out);
    meas(18'h00514, 18'h009C4, -13'sh0384);
    cur_thr_unearthed_in <= 18'h007D0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("setting change", 1'b0, pickup_out);
    cur_thr_unearthed_in <= CUR_DEFAULT;
    grounding_type_in <= GND_GROUNDED;
    meas(18'h00514, 18'h009C4, 13'sh0000);
    chk("sector inside", 1'b1, pickup_unearthed_out);
    meas(18'h00514, 18'h009C4, 13'sh04B0);
    chk("sector outside", 1'b0, pickup_out);
    sector_centre_in <= 13'sh04B0;
    meas(18'h00514, 18'h009C4, 13'sh04B0);
    chk("sector rotated", 1'b1, pickup_unearthed_out);
    grounding_type_in <= GND_COMPENSATED;
    blinder_angle_in <= 13'sh0000;
    meas(18'h00514, 18'h009C4, 13'sh06FE);
    chk("compensated forward", 1'b1, pickup_compensated_out);
    chk("compensated or", 1'b1, pickup_out);
    meas(18'h00514, 18'h009C4, -13'sh03E8);
    chk("blinder off", 1'b1, pickup_compensated_out);
    blinder_angle_in <= -13'sh01C2;
    meas(18'h00514, 18'h009C4, -13'sh03E8);
    chk("blinder on", 1'b0, pickup_compensated_out);
    grounding_type_in <= GND_BROAD;
    blinder_angle_in <= BLIND_DEF;
    meas(18'h00514, 18'h009C4, -13'sh06A4);
    chk("broad compensated", 1'b1, pickup_compensated_out);
    chk("broad not unearthed", 1'b0, pickup_unearthed_out);
    meas(18'h00514, 18'h009C4, -13'sh03E8);
    chk("broad unearthed", 1'b1, pickup_unearthed_out);
    chk("broad border", 1'b0, pickup_compensated_out);
    mcd_enable_in <= 1'b1;
    meas(18'h00514, 18'h009C4, -13'sh06A4);
    chk("mcd no fault", 1'b0, pickup_compensated_out);
    mcd_fault_in <= 1'b1;
    meas(18'h00514, 18'h009C4, -13'sh06A4);
    chk("mcd fault", 1'b1, pickup_compensated_out);
    tally_and_finish();
  end
endmodule
